// ---- hw/sbdf_framer.v ----
// bulk-dump framer: parses requests and dumps, transmits automix dumps
`include "sbdf_consts.vh"

// Contract
// - Every bulk message opens with byte f0 and closes with byte f7.
// - A library request is f0 id 2n 7e sig 48 then library 0-63, f7.
// - An automix request has type 41 then automix 0-15 and f7.
// - A dump has sub 0n, format 7e, count 2078, title and 1024 words.
// - A dump carries a 7-bit block count pair, high first, 0 to size.
// - A dump carries size minus one as a 7-bit pair, then a checksum.
module sbdf_framer #(
  parameter [7:0] MFR_ID = 8'h7d,            // arbitrary value
  parameter [63:0] SIG_WORD = 64'h5344554d50202031 // arbitrary value
) (
  input wire clk_sys,
  input wire resetn,
  input wire [3:0] cfg_channel,
  input wire [7:0] rx_byte,
  input wire rx_valid,
  output reg req_chlib_pulse,
  output reg req_automix_pulse,
  output reg [6:0] req_item_selector,
  output reg rx_pl_valid,
  output reg [6:0] rx_pl_byte,
  output reg [11:0] rx_pl_index,
  output reg dump_ok_pulse,
  output reg dump_bad_pulse,
  output reg [3:0] dump_automix_num,
  output reg [13:0] dump_block_cnt,
  output reg [13:0] dump_size_m1,
  input wire tx_start,
  input wire [3:0] tx_automix_num,
  input wire [13:0] tx_block_cnt,
  input wire [14:0] tx_total_size,
  output wire tx_busy,
  output reg [7:0] tx_byte,
  output reg tx_valid,
  input wire tx_ready,
  input wire [6:0] pl_byte,
  input wire pl_valid,
  output wire pl_ready
);
  localparam [3:0] R_IDLE = 4'd0;
  localparam [3:0] R_ID = 4'd1;
  localparam [3:0] R_SUB = 4'd2;
  localparam [3:0] R_FMT = 4'd3;
  localparam [3:0] R_CNT = 4'd4;
  localparam [3:0] R_SIG = 4'd5;
  localparam [3:0] R_TYPE = 4'd6;
  localparam [3:0] R_SEL = 4'd7;
  localparam [3:0] R_BODY = 4'd8;
  localparam [3:0] R_SUM = 4'd9;
  localparam [3:0] R_EOX = 4'd10;

  reg [3:0] rx_st_reg;
  reg [11:0] rx_cnt_reg;
  reg rx_dump_reg;
  reg rx_chlib_reg;
  reg [6:0] rx_sum_reg;
  reg rx_sum_ok_reg;
  reg [6:0] rx_sel_reg;
  reg [6:0] rx_hi_reg;

  wire [2:0] rx_sig_sel = 3'd7 - rx_cnt_reg[2:0];
  wire [7:0] rx_sig_byte = SIG_WORD[{rx_sig_sel, 3'b000} +: 8];
  wire [6:0] rx_sum_next = rx_sum_reg + rx_byte[6:0];
  wire [11:0] rx_pl_pos = rx_cnt_reg - `SBDF_FIELD_LEN;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_st_reg <= R_IDLE;
      rx_cnt_reg <= 12'h000;
      rx_dump_reg <= 1'b0;
      rx_chlib_reg <= 1'b0;
      rx_sum_reg <= 7'h00;
      rx_sum_ok_reg <= 1'b0;
      rx_sel_reg <= 7'h00;
      rx_hi_reg <= 7'h00;
      req_chlib_pulse <= 1'b0;
      req_automix_pulse <= 1'b0;
      req_item_selector <= 7'h00;
      rx_pl_valid <= 1'b0;
      rx_pl_byte <= 7'h00;
      rx_pl_index <= 12'h000;
      dump_ok_pulse <= 1'b0;
      dump_bad_pulse <= 1'b0;
      dump_automix_num <= 4'h0;
      dump_block_cnt <= 14'h0000;
      dump_size_m1 <= 14'h0000;
    end else begin
      req_chlib_pulse <= 1'b0;
      req_automix_pulse <= 1'b0;
      rx_pl_valid <= 1'b0;
      dump_ok_pulse <= 1'b0;
      dump_bad_pulse <= 1'b0;
      // real-time bytes may interleave anywhere and are transparent
      if (rx_valid && rx_byte < `SBDF_RT_MIN) begin
        if (rx_byte == `SBDF_SOX) begin
          rx_st_reg <= R_ID;
        end else if (rx_st_reg == R_IDLE) begin
          rx_st_reg <= R_IDLE;
        end else if (rx_byte[7] && !(rx_st_reg == R_EOX &&
                                     rx_byte == `SBDF_EOX)) begin
          rx_st_reg <= R_IDLE; // truncated message is dropped
        end else begin
          case (rx_st_reg)
            R_ID: begin
              rx_st_reg <= (rx_byte == MFR_ID) ? R_SUB : R_IDLE;
            end
            R_SUB: begin
              if (rx_byte[3:0] != cfg_channel) begin
                rx_st_reg <= R_IDLE;
              end else if (rx_byte[7:4] == `SBDF_SUB_REQ) begin
                rx_dump_reg <= 1'b0;
                rx_st_reg <= R_FMT;
              end else if (rx_byte[7:4] == `SBDF_SUB_DUMP) begin
                rx_dump_reg <= 1'b1;
                rx_st_reg <= R_FMT;
              end else begin
                rx_st_reg <= R_IDLE;
              end
            end
            R_FMT: begin
              rx_cnt_reg <= 12'h000;
              rx_sum_reg <= 7'h00;
              if (rx_byte != `SBDF_FMT)
                rx_st_reg <= R_IDLE;
              else
                rx_st_reg <= rx_dump_reg ? R_CNT : R_SIG;
            end
            R_CNT: begin
              // fixed byte count of 2078
              if (rx_cnt_reg == 12'h000) begin
                rx_cnt_reg <= 12'h001;
                if (rx_byte != `SBDF_CNT_HI)
                  rx_st_reg <= R_IDLE;
              end else begin
                rx_cnt_reg <= 12'h000;
                rx_st_reg <= (rx_byte == `SBDF_CNT_LO) ? R_SIG : R_IDLE;
              end
            end
            R_SIG: begin
              rx_sum_reg <= rx_sum_next;
              rx_cnt_reg <= rx_cnt_reg + 12'h001;
              if (rx_byte != rx_sig_byte)
                rx_st_reg <= R_IDLE;
              else if (rx_cnt_reg[2:0] == 3'd7)
                rx_st_reg <= R_TYPE;
            end
            R_TYPE: begin
              rx_sum_reg <= rx_sum_next;
              rx_chlib_reg <= (rx_byte == `SBDF_TYPE_CHLIB);
              if (rx_byte == `SBDF_TYPE_AMIX)
                rx_st_reg <= R_SEL;
              else if (rx_byte == `SBDF_TYPE_CHLIB && !rx_dump_reg)
                rx_st_reg <= R_SEL;
              else
                rx_st_reg <= R_IDLE;
            end
            R_SEL: begin
              rx_sum_reg <= rx_sum_next;
              rx_sel_reg <= rx_byte[6:0];
              rx_cnt_reg <= 12'h000;
              // library 0-63, automix 0-15
              if (rx_chlib_reg ? rx_byte[6] : (rx_byte[6:4] != 3'h0))
                rx_st_reg <= R_IDLE;
              else
                rx_st_reg <= rx_dump_reg ? R_BODY : R_EOX;
            end
            R_BODY: begin
              rx_sum_reg <= rx_sum_next;
              rx_cnt_reg <= rx_cnt_reg + 12'h001;
              case (rx_cnt_reg)
                12'd0: rx_hi_reg <= rx_byte[6:0];
                12'd1: dump_block_cnt <= {rx_hi_reg,rx_byte[6:0]};
                12'd2: rx_hi_reg <= rx_byte[6:0];
                12'd3: dump_size_m1 <= {rx_hi_reg, rx_byte[6:0]};
                default: begin
                  // consumer must hold data until dump_ok, since bad
                  // checksums are only known at the end
                  rx_pl_valid <= 1'b1;
                  rx_pl_byte <= rx_byte[6:0];
                  rx_pl_index <= rx_pl_pos;
                end
              endcase
              if (rx_cnt_reg == `SBDF_BODY_LAST)
                rx_st_reg <= R_SUM;
            end
            R_SUM: begin
              rx_sum_ok_reg <= (rx_sum_next == 7'h00);
              rx_st_reg <= R_EOX;
            end
            R_EOX: begin
              rx_st_reg <= R_IDLE;
              if (rx_byte == `SBDF_EOX) begin
                if (rx_dump_reg) begin
                  dump_ok_pulse <= rx_sum_ok_reg;
                  dump_bad_pulse <= !rx_sum_ok_reg;
                  dump_automix_num <= rx_sel_reg[3:0];
                end else begin
                  req_chlib_pulse <= rx_chlib_reg;
                  req_automix_pulse <= !rx_chlib_reg;
                  req_item_selector <= rx_sel_reg;
                end
              end
            end
            default: rx_st_reg <= R_IDLE;
          endcase
        end
      end
    end
  end

  // transmit side: one automix dump per start, payload pulled from user
  reg tx_active_reg;
  reg [11:0] tx_pos_reg;
  reg [6:0] tx_sum_reg;
  reg [3:0] tx_num_reg;
  reg [13:0] tx_blk_reg;
  reg [13:0] tx_szm1_reg;
  reg [7:0] tx_mux;

  wire tx_in_pl = tx_pos_reg >= `SBDF_POS_PL && tx_pos_reg <= `SBDF_POS_PLEND;
  wire tx_room = !tx_valid || tx_ready;
  wire tx_load = tx_active_reg && tx_room && (!tx_in_pl || pl_valid);
  wire tx_in_sum = tx_pos_reg >= `SBDF_POS_SIG &&
                   tx_pos_reg <= `SBDF_POS_PLEND;
  wire [6:0] tx_chk = 7'h00 - tx_sum_reg;
  wire [11:0] tx_sig_idx = tx_pos_reg - `SBDF_POS_SIG;
  wire [2:0] tx_sig_sel = 3'd7 - tx_sig_idx[2:0];

  assign pl_ready = tx_active_reg && tx_room && tx_in_pl;
  assign tx_busy = tx_active_reg || tx_valid;

  always @* begin
    tx_mux = {1'b0, pl_byte};
    if (tx_pos_reg == 12'd0)
      tx_mux = `SBDF_SOX;
    else if (tx_pos_reg == 12'd1)
      tx_mux = MFR_ID;
    else if (tx_pos_reg == `SBDF_POS_SUB)
      tx_mux = {`SBDF_SUB_DUMP, cfg_channel};
    else if (tx_pos_reg == `SBDF_POS_FMT)
      tx_mux = `SBDF_FMT;
    else if (tx_pos_reg == `SBDF_POS_CNTH)
      tx_mux = `SBDF_CNT_HI;
    else if (tx_pos_reg == `SBDF_POS_CNTL)
      tx_mux = `SBDF_CNT_LO;
    else if (tx_pos_reg < `SBDF_POS_TYPE)
      tx_mux = SIG_WORD[{tx_sig_sel, 3'b000} +: 8];
    else if (tx_pos_reg == `SBDF_POS_TYPE)
      tx_mux = `SBDF_TYPE_AMIX;
    else if (tx_pos_reg == `SBDF_POS_SEL)
      tx_mux = {4'h0, tx_num_reg};
    else if (tx_pos_reg == `SBDF_POS_BLKH)
      tx_mux = {1'b0, tx_blk_reg[13:7]};
    else if (tx_pos_reg == `SBDF_POS_BLKL)
      tx_mux = {1'b0, tx_blk_reg[6:0]};
    else if (tx_pos_reg == `SBDF_POS_SZH)
      tx_mux = {1'b0, tx_szm1_reg[13:7]};
    else if (tx_pos_reg == `SBDF_POS_SZL)
      tx_mux = {1'b0, tx_szm1_reg[6:0]};
    else if (tx_pos_reg == `SBDF_POS_SUM)
      tx_mux = {1'b0, tx_chk};
    else if (tx_pos_reg == `SBDF_POS_EOX)
      tx_mux = `SBDF_EOX;
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_active_reg <= 1'b0;
      tx_pos_reg <= 12'h000;
      tx_sum_reg <= 7'h00;
      tx_num_reg <= 4'h0;
      tx_blk_reg <= 14'h0000;
      tx_szm1_reg <= 14'h0000;
      tx_byte <= 8'h00;
      tx_valid <= 1'b0;
    end else begin
      if (tx_start && !tx_busy) begin
        tx_active_reg <= 1'b1;
        tx_pos_reg <= 12'h000;
        tx_sum_reg <= 7'h00;
        tx_num_reg <= tx_automix_num;
        tx_blk_reg <= tx_block_cnt;
        // size field carries size minus one
        tx_szm1_reg <= tx_total_size[13:0] - 14'h0001;
      end else if (tx_load) begin
        tx_byte <= tx_mux;
        tx_valid <= 1'b1;
        tx_pos_reg <= tx_pos_reg + 12'h001;
        if (tx_in_sum)
          tx_sum_reg <= tx_sum_reg + tx_mux[6:0];
        if (tx_pos_reg == `SBDF_POS_EOX)
          tx_active_reg <= 1'b0;
      end else if (tx_ready) begin
        tx_valid <= 1'b0;
      end
    end
  end
endmodule

// ---- hw/sbdf_consts.vh ----
// constants for the bulk-dump framer: bytes, field positions, lengths
`ifndef SBDF_CONSTS_VH
`define SBDF_CONSTS_VH
`define SBDF_SOX 8'hf0
`define SBDF_EOX 8'hf7
`define SBDF_RT_MIN 8'hf8
`define SBDF_FMT 8'h7e
`define SBDF_SUB_REQ 4'h2
`define SBDF_SUB_DUMP 4'h0
`define SBDF_TYPE_CHLIB 8'h48
`define SBDF_TYPE_AMIX 8'h41
`define SBDF_CNT_HI 8'h10
`define SBDF_CNT_LO 8'h1e
`define SBDF_BODY_LAST 12'd2067
`define SBDF_FIELD_LEN 12'd4
`define SBDF_POS_SUB 12'd2
`define SBDF_POS_FMT 12'd3
`define SBDF_POS_CNTH 12'd4
`define SBDF_POS_CNTL 12'd5
`define SBDF_POS_SIG 12'd6
`define SBDF_POS_TYPE 12'd14
`define SBDF_POS_SEL 12'd15
`define SBDF_POS_BLKH 12'd16
`define SBDF_POS_BLKL 12'd17
`define SBDF_POS_SZH 12'd18
`define SBDF_POS_SZL 12'd19
`define SBDF_POS_PL 12'd20
`define SBDF_POS_PLEND 12'd2083
`define SBDF_POS_SUM 12'd2084
`define SBDF_POS_EOX 12'd2085
`endif

// ---- sim/sbdf_framer_monitor.sv ----
// checker for the bulk-dump framer ports
module sbdf_framer_monitor (
  input wire clk_sys,
  input wire resetn,
  input wire [7:0] rx_byte,
  input wire rx_valid,
  input wire req_chlib_pulse,
  input wire req_automix_pulse,
  input wire [6:0] req_item_selector,
  input wire rx_pl_valid,
  input wire [11:0] rx_pl_index,
  input wire dump_ok_pulse,
  input wire dump_bad_pulse,
  input wire [13:0] dump_block_cnt,
  input wire [13:0] dump_size_m1,
  input wire tx_start,
  input wire tx_busy,
  input wire [7:0] tx_byte,
  input wire tx_valid,
  input wire tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_chlib_on_eox: assert property (req_chlib_pulse |->
    $past(rx_valid && rx_byte == 8'hf7) && req_item_selector < 7'd64)
    else $error("library request pulse without end byte");
  a_amix_on_eox: assert property (req_automix_pulse |->
    $past(rx_valid && rx_byte == 8'hf7) && req_item_selector < 7'd16)
    else $error("automix request pulse without end byte");
  a_dump_verdict: assert property (dump_ok_pulse ||
    dump_bad_pulse |-> $past(rx_valid && rx_byte == 8'hf7) &&
    !(dump_ok_pulse && dump_bad_pulse)) else $error("dump verdict wrong");
  a_rx_pl_follow: assert property (rx_pl_valid |->
    $past(rx_valid && rx_byte < 8'h80) && rx_pl_index < 12'd2064)
    else $error("payload byte without cause");
  a_blk_update: assert property (!$stable(dump_block_cnt) |->
    $past(rx_valid && rx_byte < 8'h80)) else $error("block count moved");
  a_size_update: assert property (!$stable(dump_size_m1) |->
    $past(rx_valid && rx_byte < 8'h80)) else $error("size field moved");
  a_tx_opens: assert property (tx_start && !tx_busy |->
    ##2 tx_valid && tx_byte == 8'hf0) else $error("transmit did not open");
  a_tx_holds: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_byte)) else $error("transmit byte dropped");
  a_tx_closes: assert property (tx_valid && tx_ready &&
    tx_byte == 8'hf7 |=> !tx_valid) else $error("byte after end byte");
endmodule
bind sbdf_framer sbdf_framer_monitor u_mon (.clk_sys(clk_sys),
  .resetn(resetn), .rx_byte(rx_byte), .rx_valid(rx_valid),
  .req_chlib_pulse(req_chlib_pulse), .req_automix_pulse(req_automix_pulse),
  .req_item_selector(req_item_selector), .rx_pl_valid(rx_pl_valid),
  .rx_pl_index(rx_pl_index), .dump_ok_pulse(dump_ok_pulse),
  .dump_bad_pulse(dump_bad_pulse), .dump_block_cnt(dump_block_cnt),
  .dump_size_m1(dump_size_m1), .tx_start(tx_start), .tx_busy(tx_busy),
  .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready));

// ---- sim/sbdf_midi_peer.sv ----
// far-side link model: stalls at random, collects the framed stream
module sbdf_midi_peer (
  input wire clk_sys,
  input wire resetn,
  input wire [7:0] tx_byte,
  input wire tx_valid,
  output logic tx_ready = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q [$];
  // mixes prompt and slow acceptance so the hold logic is exercised
  always @(negedge clk_sys) tx_ready = resetn && ($urandom % 3 != 0);
  always @(posedge clk_sys)
    if (tx_valid && tx_ready) q.push_back(tx_byte);
endmodule

// ---- sim/sbdf_framer_tb_top.sv ----
// bench: byte-level model of requests and dumps compared with the framer
module sbdf_framer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [7:0] MFR = 8'h7d; // arbitrary value
  localparam [63:0] SIG = 64'h5344554d50202031; // arbitrary value
  logic clk_sys = 0, resetn = 0, rx_valid = 0, tx_start = 0, pl_valid = 0;
  logic [3:0] cfg_channel = 4'h5, tx_automix_num = 0, nm;
  logic [7:0] rx_byte = 0;
  logic [13:0] tx_block_cnt = 0, b, z;
  logic [14:0] tx_total_size = 0;
  logic [6:0] pl_byte = 0;
  wire req_chlib_pulse, req_automix_pulse, rx_pl_valid, dump_ok_pulse;
  wire dump_bad_pulse, tx_busy, tx_valid, tx_ready, pl_ready;
  wire [6:0] req_item_selector, rx_pl_byte;
  wire [11:0] rx_pl_index;
  wire [3:0] dump_automix_num;
  wire [13:0] dump_block_cnt, dump_size_m1;
  wire [7:0] tx_byte;
  logic [6:0] pl [0:2063];
  logic [7:0] m [$];
  logic [25:0] tbl [0:7];
  int s, c, a, pi, tk, n_cl, n_am, n_ok, n_bad, n_pl, bad_pl, cyc;
  int num_errors, num_checks;
  sbdf_framer #(.MFR_ID(MFR), .SIG_WORD(SIG)) u_sbdf_framer (
    .clk_sys(clk_sys), .resetn(resetn), .cfg_channel(cfg_channel),
    .rx_byte(rx_byte), .rx_valid(rx_valid),
    .req_chlib_pulse(req_chlib_pulse), .req_automix_pulse(req_automix_pulse),
    .req_item_selector(req_item_selector), .rx_pl_valid(rx_pl_valid),
    .rx_pl_byte(rx_pl_byte), .rx_pl_index(rx_pl_index),
    .dump_ok_pulse(dump_ok_pulse), .dump_bad_pulse(dump_bad_pulse),
    .dump_automix_num(dump_automix_num), .dump_block_cnt(dump_block_cnt),
    .dump_size_m1(dump_size_m1), .tx_start(tx_start),
    .tx_automix_num(tx_automix_num), .tx_block_cnt(tx_block_cnt),
    .tx_total_size(tx_total_size), .tx_busy(tx_busy), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .pl_byte(pl_byte),
    .pl_valid(pl_valid), .pl_ready(pl_ready));
  sbdf_midi_peer u_peer (.clk_sys(clk_sys), .resetn(resetn),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready));
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    n_cl += req_chlib_pulse;
    n_am += req_automix_pulse;
    n_ok += dump_ok_pulse;
    n_bad += dump_bad_pulse;
    if (rx_pl_valid) begin
      n_pl++;
      bad_pl += (rx_pl_byte !== pl[rx_pl_index]);
    end
    tk = pl_valid && pl_ready;
    pi += tk;
    if (cyc == 40000) begin
      num_errors++;
      end_sim();
    end
  end
  // payload source holds a byte until it is taken, then may pause
  always @(negedge clk_sys) begin
    pl_byte = pl[pi % 2064];
    if (!pl_valid || tk) pl_valid = $urandom % 4 != 0;
  end
  task chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  task end_sim();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task put(input [7:0] v);
    m.push_back(v);
    if (m.size() > 6) s += v;
  endtask
  task sig(input [7:0] ty);
    for (int i = 7; i >= 0; i--) put(SIG[i*8 +: 8]);
    put(ty);
  endtask
  task dump(input [3:0] ch, input [3:0] n, input [13:0] bk, input [13:0] sz,
    input [6:0] bad);
    m = {};
    s = 0;
    put(8'hf0);
    put(MFR);
    put({4'h0, ch});
    put(8'h7e);
    put(8'h10);
    put(8'h1e);
    sig(8'h41);
    put({4'h0, n});
    put({1'b0, bk[13:7]});
    put({1'b0, bk[6:0]});
    put({1'b0, sz[13:7]});
    put({1'b0, sz[6:0]});
    for (int i = 0; i < 2064; i++) put({1'b0, pl[i]});
    put({1'b0, 7'(bad - s)});
    put(8'hf7);
  endtask
  task send();
    foreach (m[i]) begin
      @(negedge clk_sys);
      rx_byte = m[i];
      rx_valid = 1;
    end
    @(negedge clk_sys);
    rx_valid = 0;
    repeat (3) @(negedge clk_sys);
  endtask
  initial begin
    void'($urandom(32'hdc25d13e));
    foreach (pl[i]) pl[i] = $urandom;
    tbl = '{{8'h25, 8'h48, 8'h00, 2'b10}, {8'h25, 8'h48, 8'h3f, 2'b10},
      {8'h25, 8'h48, 8'h40, 2'b00}, {8'h24, 8'h48, 8'h01, 2'b00},
      {8'h25, 8'h41, 8'h00, 2'b01}, {8'h25, 8'h41, 8'h0f, 2'b01},
      {8'h25, 8'h41, 8'h10, 2'b00}, {8'h25, 8'h42, 8'h03, 2'b00}};
    repeat (2) @(negedge clk_sys);
    resetn = 1;
    foreach (tbl[k]) begin
      c = n_cl;
      a = n_am;
      m = {};
      put(8'hf0);
      put(MFR);
      put(tbl[k][25:18]);
      put(8'h7e);
      // real-time bytes may interleave and must not disturb the parse
      if (k == 1) put(8'hf8);
      sig(tbl[k][17:10]);
      put(tbl[k][9:2]);
      put(8'hf7);
      send();
      chk(n_cl === c + tbl[k][1] &&
        n_am === a + tbl[k][0], "req pulse");
      if (tbl[k][1:0] != 0)
        chk(req_item_selector === tbl[k][8:2], "sel");
    end
    $display("request test done");
    for (int k = 0; k < 3; k++) begin
      c = n_ok;
      a = n_bad;
      n_pl = 0;
      bad_pl = 0;
      z = $urandom;
      b = $urandom % (z + 1);
      nm = $urandom;
      dump(k == 2 ? 4'h6 : 4'h5, nm, b, z, 7'(k == 1));
      send();
      chk(n_ok === c + (k == 0) &&
        n_bad === a + (k == 1), "verdict");
      if (k == 0) begin
        chk(dump_block_cnt === b, "block count");
        chk(dump_size_m1 === z, "size field");
        chk(dump_automix_num === nm && n_pl === 2064, "dump");
        chk(bad_pl === 0, "payload");
      end
    end
    $display("receive test done");
    tx_automix_num = $urandom;
    tx_total_size = 15'd16384;
    tx_block_cnt = 14'h3fff;
    pi = 0;
    tx_start = 1;
    repeat (3) @(negedge clk_sys);
    tx_start = 0;
    c = 0;
    while (tx_busy !== 1'b0 && c < 20000) begin
      @(negedge clk_sys);
      c++;
    end
    dump(cfg_channel, tx_automix_num, tx_block_cnt, 14'h3fff, 7'h00);
    a = 0;
    foreach (m[i]) a += (u_peer.q[i] !== m[i]);
    chk(u_peer.q.size() === 2086 && c < 20000, "tx length");
    chk(a === 0, "tx stream");
    $display("transmit test done");
    end_sim();
  end
endmodule
